// ### hdl/vic_pkg.sv
// constants for the vectored interrupt classifier
package vcl_pkg;
	// ****************************************
	// channel layout
	// ****************************************
	localparam int NUM_CHANNELS = 32;
	localparam int CH_EXT_ZERO = 14;
	localparam int CH_EXT_ONE = 15;
	localparam int CH_EXT_TWO = 16;
	localparam int CH_EXT_THREE = 17;
	localparam int CH_CONVERTER = 18;
	localparam int VECT_SLOTS = 16;
	localparam int SLOT_BITS = 4;
	localparam int CHAN_BITS = 5;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [31:0] FAST_SEL_RESET = 32'h0000_0000;
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [31:0] VECT_EN_RESET = 32'h0000_0000;
	localparam logic [4:0] SLOT_CHAN_RESET = 5'h00;
endpackage

// ### hdl/vic_vect_pick.sv
// priority picker over the vectored slots
`timescale 1ns/1ps
`default_nettype none
module vcl_vect_pick
#(
	parameter int SLOTS = vcl_pkg::VECT_SLOTS,
	parameter int SBITS = vcl_pkg::SLOT_BITS
)
(
	input wire logic [SLOTS-1:0] slot_req_i,
	output logic hit_o,
	output logic [SBITS-1:0] slot_o
);
	// lowest slot number wins: slot order is the programmable priority
	always_comb
	begin
		hit_o = 1'b0;
		slot_o = '0;
		for (int i = SLOTS - 1; i >= 0; i--)
		begin
			if (slot_req_i[i])
			begin
				hit_o = 1'b1;
				slot_o = SBITS'(i);
			end
		end
	end
endmodule // vcl_vect_pick
`default_nettype wire

// ### hdl/vic_classifier.sv
// interrupt classifier top: fast, vectored and plain normal classes
`timescale 1ns/1ps
`default_nettype none
module vcl_classifier
#(
	parameter int NCH = vcl_pkg::NUM_CHANNELS,
	parameter int SLOTS = vcl_pkg::VECT_SLOTS,
	parameter int SBITS = vcl_pkg::SLOT_BITS,
	parameter int CBITS = vcl_pkg::CHAN_BITS
)
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [NCH-1:0] periph_req_i,
	input wire logic ext_request_zero_i,
	input wire logic ext_request_one_i,
	input wire logic ext_request_two_i,
	input wire logic ext_request_three_i,
	input wire logic conv_done_req_i,
	input wire logic cfg_we_i,
	input wire logic [NCH-1:0] cfg_fast_sel_i,
	input wire logic [NCH-1:0] cfg_enable_i,
	input wire logic [SLOTS-1:0] cfg_vect_en_i,
	input wire logic [SLOTS*CBITS-1:0] cfg_slot_chan_i,
	output logic fast_request_line_o,
	output logic normal_request_o,
	output logic [NCH-1:0] fast_status_o,
	output logic vect_valid_o,
	output logic [SBITS-1:0] vect_slot_o,
	output logic [NCH-1:0] fast_sel_o
);
	// ****************************************
	// channel assembly
	// ****************************************
	logic [NCH-1:0] raw_req;
	// dedicated lines override whatever the generic bus carries there
	always_comb
	begin
		raw_req = periph_req_i;
		raw_req[vcl_pkg::CH_EXT_ZERO] = ext_request_zero_i;
		raw_req[vcl_pkg::CH_EXT_ONE] = ext_request_one_i;
		raw_req[vcl_pkg::CH_EXT_TWO] = ext_request_two_i;
		raw_req[vcl_pkg::CH_EXT_THREE] = ext_request_three_i;
		raw_req[vcl_pkg::CH_CONVERTER] = conv_done_req_i;
	end

	// ****************************************
	// class settings
	// ****************************************
	logic [NCH-1:0] fast_sel_reg;
	logic [NCH-1:0] enable_reg;
	logic [SLOTS-1:0] vect_en_reg;
	logic [CBITS-1:0] slot_chan_reg [SLOTS];
	// settings load at any time, so priorities move without a reset
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			fast_sel_reg <= NCH'(vcl_pkg::FAST_SEL_RESET);
			enable_reg <= NCH'(vcl_pkg::ENABLE_RESET);
			vect_en_reg <= SLOTS'(vcl_pkg::VECT_EN_RESET);
		end
		else if (cfg_we_i)
		begin
			fast_sel_reg <= cfg_fast_sel_i;
			enable_reg <= cfg_enable_i;
			vect_en_reg <= cfg_vect_en_i;
		end
	end

	// slot channel numbers pick which source holds each priority slot
	always_ff @(posedge clk_i)
	begin
		for (int s = 0; s < SLOTS; s++)
		begin
			if (sys_rst_i)
				slot_chan_reg[s] <= CBITS'(vcl_pkg::SLOT_CHAN_RESET);
			else if (cfg_we_i)
				slot_chan_reg[s] <= cfg_slot_chan_i[s*CBITS +: CBITS];
		end
	end

	// ****************************************
	// classification
	// ****************************************
	logic [NCH-1:0] live_req;
	logic [NCH-1:0] fast_req;
	logic [NCH-1:0] norm_req;
	logic [SLOTS-1:0] slot_req;
	logic vect_hit;
	logic [SBITS-1:0] vect_slot;
	assign live_req = raw_req & enable_reg;
	assign fast_req = live_req & fast_sel_reg;
	assign norm_req = live_req & ~fast_sel_reg;
	// a vectored slot only sees its source while that source is normal
	always_comb
	begin
		for (int s = 0; s < SLOTS; s++)
			slot_req[s] = vect_en_reg[s] & norm_req[slot_chan_reg[s]];
	end

	vcl_vect_pick #(.SLOTS(SLOTS), .SBITS(SBITS)) u_pick
	(
		.slot_req_i(slot_req),
		.hit_o(vect_hit),
		.slot_o(vect_slot)
	);

	// ****************************************
	// outputs to the core
	// ****************************************
	// registered outputs; fast line never waits on the normal path
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			fast_request_line_o <= 1'b0;
			fast_status_o <= '0;
		end
		else
		begin
			fast_request_line_o <= |fast_req;
			fast_status_o <= fast_req;
		end
	end

	// normal class held off the vector while fast work is pending
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			normal_request_o <= 1'b0;
			vect_valid_o <= 1'b0;
			vect_slot_o <= '0;
		end
		else
		begin
			normal_request_o <= |norm_req;
			vect_valid_o <= vect_hit & ~(|fast_req);
			vect_slot_o <= vect_slot;
		end
	end

	assign fast_sel_o = fast_sel_reg;

	// ****************************************
	// checks
	// ****************************************
	property p_fast_merge;
		@(posedge clk_i) disable iff (sys_rst_i)
		|(raw_req & enable_reg & fast_sel_reg) |=> fast_request_line_o;
	endproperty
	a_fast_merge: assert property (p_fast_merge) else $error("fast line missed");

	property p_fast_idle;
		@(posedge clk_i) disable iff (sys_rst_i)
		!(|(raw_req & enable_reg & fast_sel_reg)) |=> !fast_request_line_o;
	endproperty
	a_fast_idle: assert property (p_fast_idle) else $error("fast line stuck");

	property p_status;
		@(posedge clk_i) disable iff (sys_rst_i)
		1'b1 |=> fast_status_o == $past(fast_req);
	endproperty
	a_status: assert property (p_status) else $error("fast status wrong");

	property p_normal;
		@(posedge clk_i) disable iff (sys_rst_i)
		|(raw_req & enable_reg & ~fast_sel_reg) |=> normal_request_o;
	endproperty
	a_normal: assert property (p_normal) else $error("normal line missed");

	property p_normal_idle;
		@(posedge clk_i) disable iff (sys_rst_i)
		!(|norm_req) |=> !normal_request_o;
	endproperty
	a_normal_idle: assert property (p_normal_idle) else $error("normal stuck");

	property p_precedence;
		@(posedge clk_i) disable iff (sys_rst_i)
		vect_valid_o |-> !fast_request_line_o;
	endproperty
	a_precedence: assert property (p_precedence) else $error("vector over fast");

	// judged on the registered outputs, so a wrong class mask shows up
	property p_classes;
		@(posedge clk_i) disable iff (sys_rst_i)
		1'b1 |=> (fast_status_o & ~$past(fast_sel_reg)) == '0
			&& (|$past(live_req))
			== (fast_request_line_o || normal_request_o);
	endproperty
	a_classes: assert property (p_classes) else $error("class overlap");

	property p_ext_zero;
		@(posedge clk_i) disable iff (sys_rst_i)
		ext_request_zero_i && enable_reg[vcl_pkg::CH_EXT_ZERO]
			&& fast_sel_reg[vcl_pkg::CH_EXT_ZERO]
			|=> fast_status_o[vcl_pkg::CH_EXT_ZERO];
	endproperty
	a_ext_zero: assert property (p_ext_zero) else $error("ext zero channel");

	property p_conv;
		@(posedge clk_i) disable iff (sys_rst_i)
		conv_done_req_i && enable_reg[vcl_pkg::CH_CONVERTER]
			&& fast_sel_reg[vcl_pkg::CH_CONVERTER]
			|=> fast_status_o[vcl_pkg::CH_CONVERTER];
	endproperty
	a_conv: assert property (p_conv) else $error("converter channel");

	property p_reclass;
		@(posedge clk_i) disable iff (sys_rst_i)
		cfg_we_i |=> fast_sel_reg == $past(cfg_fast_sel_i);
	endproperty
	a_reclass: assert property (p_reclass) else $error("reclass lost");

	// slot zero is the top programmable priority among vectored sources
	property p_vslot;
		@(posedge clk_i) disable iff (sys_rst_i)
		slot_req[0] && !(|fast_req) |=> vect_valid_o && vect_slot_o == '0;
	endproperty
	a_vslot: assert property (p_vslot) else $error("slot order");

	property p_vnone;
		@(posedge clk_i) disable iff (sys_rst_i)
		!(|slot_req) |=> !vect_valid_o;
	endproperty
	a_vnone: assert property (p_vnone) else $error("vector unasked");

	property p_vfast;
		@(posedge clk_i) disable iff (sys_rst_i)
		|fast_req |=> !vect_valid_o && fast_request_line_o;
	endproperty
	a_vfast: assert property (p_vfast) else $error("fast not first");
endmodule // vcl_classifier
`default_nettype wire

// ### verif/vic_core_model.sv
// core-side model of the two interrupt lines
`timescale 1ns/1ps
`default_nettype none
module vcl_core_model
(
	input wire logic clk_i,
	input wire logic fast_i,
	input wire logic normal_i,
	output logic [1:0] taken_o
);
	// the core enters fast service ahead of normal service
	always_ff @(posedge clk_i)
		taken_o <= fast_i ? 2'h2 : (normal_i ? 2'h1 : 2'h0);
endmodule // vcl_core_model
`default_nettype wire

// ### verif/vic_classifier_test.sv
// self-checking bench for the interrupt classifier
`timescale 1ns/1ps
`default_nettype none
module vcl_classifier_test;
	logic clk_i, sys_rst_i, cfg_we_i, conv_done_req_i;
	logic [3:0] ext;
	logic [31:0] periph_req_i, cfg_fast_sel_i, cfg_enable_i, fst, fso;
	logic [15:0] cfg_vect_en_i;
	logic [79:0] cfg_slot_chan_i;
	logic fq, nq, vv;
	logic [3:0] vs;
	logic [1:0] taken;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	vcl_classifier dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.periph_req_i(periph_req_i), .ext_request_zero_i(ext[0]),
		.ext_request_one_i(ext[1]), .ext_request_two_i(ext[2]),
		.ext_request_three_i(ext[3]), .conv_done_req_i(conv_done_req_i),
		.cfg_we_i(cfg_we_i), .cfg_fast_sel_i(cfg_fast_sel_i),
		.cfg_enable_i(cfg_enable_i), .cfg_vect_en_i(cfg_vect_en_i),
		.cfg_slot_chan_i(cfg_slot_chan_i), .fast_request_line_o(fq),
		.normal_request_o(nq), .fast_status_o(fst), .vect_valid_o(vv),
		.vect_slot_o(vs), .fast_sel_o(fso));
	vcl_core_model core (.clk_i(clk_i), .fast_i(fq), .normal_i(nq),
		.taken_o(taken));
	// ****************************************
	// clock, timeout and shared tasks
	// ****************************************
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// tests need well under a hundred cycles
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// inputs always move 1 ns after the edge to stay off the sampling point
	task automatic step();
		@(posedge clk_i);
		#1;
	endtask
	// a write strobe lands at the next edge, outputs follow one edge later
	task automatic cfg(input logic [31:0] f, e, input logic [15:0] v,
		input logic [79:0] s);
		cfg_fast_sel_i = f;
		cfg_enable_i = e;
		cfg_vect_en_i = v;
		cfg_slot_chan_i = s;
		cfg_we_i = 1'b1;
		step();
		cfg_we_i = 1'b0;
		step();
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_map();
		cfg(32'h0007_c000, 32'h0007_c000, 16'h0000, 80'h0);
		for (int i = 0; i < 5; i++)
		begin
			{conv_done_req_i, ext} = 5'h01 << i;
			step();
			chk("fast_status", fst, 32'h1 << (14 + i));
			chk("fast_line", {31'h0, fq}, 32'h1);
		end
		{conv_done_req_i, ext} = 5'h00;
		periph_req_i = 32'h0007_c000;
		step();
		chk("replaced_bits", fst, 32'h0);
	endtask
	task automatic t_merge();
		cfg(32'h0000_0028, 32'h0000_00a8, 16'h0000, 80'h0);
		periph_req_i = 32'h0000_00a8;
		step();
		chk("fast_merge", fst, 32'h28);
		chk("lines", {30'h0, fq, nq}, 32'h3);
		step();
		chk("core_take", {30'h0, taken}, 32'h2);
		periph_req_i = 32'h0000_0008;
		step();
		chk("lines", {30'h0, fq, nq}, 32'h2);
		periph_req_i = 32'h0;
		step();
		chk("lines", {30'h0, fq, nq}, 32'h0);
	endtask
	task automatic t_prec();
		cfg(32'h0000_0008, 32'h0000_0288, 16'h0001, 80'h7);
		periph_req_i = 32'h0000_0080;
		step();
		chk("vectored", {27'h0, vv, vs}, 32'h10);
		periph_req_i = 32'h0000_0088;
		step();
		chk("fast_first", {29'h0, fq, nq, vv}, 32'h6);
		periph_req_i = 32'h0000_0210;
		step();
		chk("plain_normal", {29'h0, fq, nq, vv}, 32'h2);
		periph_req_i = 32'h0000_0080;
		cfg(32'h0000_0088, 32'h0000_0288, 16'h0001, 80'h7);
		chk("reclass", {29'h0, fq, nq, vv}, 32'h4);
		chk("reclass_status", fst, 32'h80);
		chk("fast_readback", fso, 32'h88);
	endtask
	// two vectored slots: lowest slot wins, then the slots are swapped live
	task automatic t_prio();
		cfg(32'h0, 32'h0000_0280, 16'h0003, 80'he9);
		periph_req_i = 32'h0000_0280;
		step();
		chk("lowest_slot", {27'h0, vv, vs}, 32'h10);
		step();
		chk("core_normal", {30'h0, taken}, 32'h1);
		periph_req_i = 32'h0000_0080;
		step();
		chk("second_slot", {27'h0, vv, vs}, 32'h11);
		cfg(32'h0, 32'h0000_0280, 16'h0003, 80'h127);
		chk("reordered", {27'h0, vv, vs}, 32'h10);
		periph_req_i = 32'h0000_0200;
		step();
		chk("moved_slot", {27'h0, vv, vs}, 32'h11);
	endtask
	// reset in mid-run clears outputs and settings; setup works again after
	task automatic t_reset();
		periph_req_i = 32'h0000_0288;
		sys_rst_i = 1'b1;
		step();
		step();
		chk("reset_lines", {29'h0, fq, nq, vv}, 32'h0);
		chk("reset_status", fst, 32'h0);
		chk("reset_select", fso, 32'h0);
		sys_rst_i = 1'b0;
		step();
		chk("all_disabled", {29'h0, fq, nq, vv}, 32'h0);
		cfg(32'h0000_0008, 32'h0000_0008, 16'h0, 80'h0);
		chk("after_reset", {29'h0, fq, nq, vv}, 32'h4);
		chk("after_status", fst, 32'h8);
	endtask
	initial
	begin
		sys_rst_i = 1'b1;
		cfg_we_i = 1'b0;
		ext = 4'h0;
		conv_done_req_i = 1'b0;
		periph_req_i = 32'h0;
		cfg_fast_sel_i = 32'h0;
		cfg_enable_i = 32'h0;
		cfg_vect_en_i = 16'h0;
		cfg_slot_chan_i = 80'h0;
		repeat (8) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		t_map();
		t_merge();
		t_prec();
		t_prio();
		t_reset();
		report_and_stop();
	end
endmodule // vcl_classifier_test
`default_nettype wire
